// ===== hdl/modbus_rtu_serial_config.sv
/*
 * Modbus RTU slave receive path: configuration registers, character
 * receiver, inter-character gap timer, CRC check and a byte FIFO.
 * Assumes the register port is the local panel side; bit rate and
 * address writes marked as coming from the link are refused.
 */
`default_nettype none
// ****************************************
// Byte FIFO with registered output stage
// ****************************************
module rx_byte_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 4
) (
    // Clock and reset
    input wire logic clk_sys_in,
    input wire logic rst_b_in,
    // Fill side
    input wire logic [WIDTH-1:0] in_data_in,
    input wire logic in_valid_in,
    output logic in_ready_out,
    // Drain side
    output logic [WIDTH-1:0] out_data_out,
    output logic out_valid_out,
    input wire logic out_ready_in
);
    localparam int AW = $clog2(DEPTH);
    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0] wr_idx;
        logic [AW-1:0] rd_idx;
        logic [AW:0] count;
        logic [WIDTH-1:0] out_data;
        logic out_valid;
    } fifo_s;
    fifo_s st, next_st;

    always_comb begin
        logic push;
        logic pop;
        push = 1'b0;
        pop = 1'b0;
        next_st = st;
        push = in_valid_in && (st.count != (AW+1)'(DEPTH));
        if (st.out_valid && out_ready_in) begin
            next_st.out_valid = 1'b0;
        end
        if (!next_st.out_valid && (st.count != '0)) begin
            pop = 1'b1;
            next_st.out_data = st.mem[st.rd_idx];
            next_st.out_valid = 1'b1;
            next_st.rd_idx = AW'((st.rd_idx + 1'b1) % DEPTH);
        end
        if (push) begin
            next_st.mem[st.wr_idx] = in_data_in;
            next_st.wr_idx = AW'((st.wr_idx + 1'b1) % DEPTH);
        end
        next_st.count = st.count + (AW+1)'(push) - (AW+1)'(pop);
    end

    always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign in_ready_out = (st.count != (AW+1)'(DEPTH));
    assign out_data_out = st.out_data;
    assign out_valid_out = st.out_valid;
endmodule : rx_byte_fifo

// ****************************************
// Top: configuration and message framer
// ****************************************
module modbus_rtu_serial_config #(
    parameter bit FOUR_PROTOCOLS = 1'b1,
    parameter int CYC_PER_BIT_FAST = modbus_cfg_pkg::CYC_PER_BIT_MAX,
    parameter int CYC_PER_TICK = modbus_cfg_pkg::CYC_PER_MS
) (
    // Clock and reset
    input wire logic clk_sys_in,
    input wire logic rst_b_in,
    // Register port
    input wire logic [7:0] reg_addr_in,
    input wire logic [15:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    input wire logic reg_from_link_in,
    output logic [15:0] reg_rdata_out,
    // Serial line
    input wire logic rx_in,
    // Received bytes
    output logic [7:0] rx_data_out,
    output logic rx_valid_out,
    input wire logic rx_ready_in,
    // Message end report
    output modbus_cfg_pkg::msg_s msg_out
);
    import modbus_cfg_pkg::*;

    typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP} rx_state_e;

    typedef struct packed {
        cfg_s cfg;
        logic [15:0] rdata;
        logic [3:0] status;
        logic [2:0] sync;
        logic line;
        rx_state_e rx;
        logic [19:0] bit_div;
        logic [3:0] bit_idx;
        logic [7:0] shift;
        logic par_acc;
        logic char_bad;
        logic [16:0] ms_div;
        logic [10:0] gap_cnt;
        logic in_msg;
        logic [15:0] crc;
        logic [3:0] nbytes;
        logic [7:0] msg_addr;
        logic msg_bad;
        logic [7:0] push_data;
        logic push;
        msg_s msg;
    } top_s;
    top_s st, next_st;

    logic fifo_ready;

    // ****************************************
    // Helpers
    // ****************************************
    function automatic logic [15:0] crc_byte(input logic [15:0] crc, input logic [7:0] data);
        logic [15:0] c;
        c = crc ^ {8'h00, data};
        for (int i = 0; i < 8; i++) begin
            c = c[0] ? ((c >> 1) ^ CRC_POLY) : (c >> 1);
        end
        return c;
    endfunction : crc_byte

    function automatic logic [19:0] bit_cycles(input logic [2:0] code);
        return 20'(CYC_PER_BIT_FAST << (BAUD_CODE_MAX - code)); // RULE_01
    endfunction : bit_cycles

    function automatic logic modbus_sel(input logic [1:0] proto);
        return proto == (FOUR_PROTOCOLS ? 2'h3 : 2'h1); // RULE_04
    endfunction : modbus_sel

    function automatic logic addr_legal(input logic [1:0] proto, input logic [7:0] a);
        if (modbus_sel(proto)) begin
            return (a >= MB_ADDR_MIN) && (a <= MB_ADDR_MAX); // RULE_10
        end
        return a <= OTHER_ADDR_MAX;
    endfunction : addr_legal

    always_comb begin
        logic accept;
        logic bit_tick;
        logic ms_tick;
        logic [19:0] bit_len;
        logic char_done;
        logic refuse;
        accept = 1'b0;
        refuse = 1'b0;
        char_done = 1'b0;
        next_st = st;
        bit_len = bit_cycles(st.cfg.baud); // RULE_02
        next_st.msg = '0;
        next_st.push = 1'b0;
        next_st.rdata = '0;

        // ****************************************
        // Register port
        // ****************************************
        if (reg_wr_in) begin
            if (reg_addr_in == OFS_BAUD) begin
                if (reg_from_link_in || (reg_wdata_in[2:0] > BAUD_CODE_MAX) || (reg_wdata_in[15:3] != '0)) begin
                    refuse = 1'b1; // RULE_03
                end else begin
                    next_st.cfg.baud = reg_wdata_in[2:0]; // RULE_01
                end
            end else if (reg_addr_in == OFS_PROTO) begin
                if ((reg_wdata_in[1:0] > (FOUR_PROTOCOLS ? 2'h3 : 2'h1)) || (reg_wdata_in[15:2] != '0)) begin
                    refuse = 1'b1;
                end else begin
                    next_st.cfg.proto = reg_wdata_in[1:0]; // RULE_04
                end
            end else if (reg_addr_in == OFS_FRAME) begin
                next_st.cfg.frame = reg_wdata_in[1:0]; // RULE_05
            end else if (reg_addr_in == OFS_GAP) begin
                if ((reg_wdata_in < 16'(GAP_MIN_MS)) || (reg_wdata_in > 16'(GAP_MAX_MS))) begin
                    refuse = 1'b1;
                end else begin
                    next_st.cfg.gap_ms = reg_wdata_in[10:0]; // RULE_07
                end
            end else if (reg_addr_in == OFS_ADDR) begin
                if (reg_from_link_in || (reg_wdata_in[15:8] != '0)
                    || !addr_legal(st.cfg.proto, reg_wdata_in[7:0])) begin
                    refuse = 1'b1; // RULE_11
                end else begin
                    next_st.cfg.slave_addr = reg_wdata_in[7:0]; // RULE_10
                end
            end else if (reg_addr_in == OFS_STATUS) begin
                next_st.status[2:0] = st.status[2:0] & ~reg_wdata_in[2:0];
            end
        end
        if (reg_rd_in) begin
            if (reg_addr_in == OFS_BAUD) begin
                next_st.rdata = 16'(st.cfg.baud);
            end else if (reg_addr_in == OFS_PROTO) begin
                next_st.rdata = 16'(st.cfg.proto);
            end else if (reg_addr_in == OFS_FRAME) begin
                next_st.rdata = 16'(st.cfg.frame);
            end else if (reg_addr_in == OFS_GAP) begin
                next_st.rdata = 16'(st.cfg.gap_ms);
            end else if (reg_addr_in == OFS_ADDR) begin
                next_st.rdata = 16'(st.cfg.slave_addr);
            end else if (reg_addr_in == OFS_STATUS) begin
                next_st.rdata = {12'h000, st.in_msg, st.status[2:0]};
            end
        end
        if (refuse) begin
            next_st.status[ST_REJECT] = 1'b1;
        end

        // ****************************************
        // Line sampling and bit divider
        // ****************************************
        next_st.sync = {st.sync[1:0], rx_in};
        if (st.sync[2] == st.sync[1]) begin
            next_st.line = st.sync[2];
        end
        bit_tick = (st.bit_div == bit_len - 20'h00001);
        next_st.bit_div = bit_tick ? '0 : st.bit_div + 20'h00001;

        // ****************************************
        // Character receiver
        // ****************************************
        case (st.rx)
            RX_IDLE: begin
                next_st.bit_div = bit_len >> 1;
                if (!st.line) begin
                    next_st.rx = RX_START;
                end
            end
            RX_START: begin
                if (bit_tick) begin
                    next_st.rx = st.line ? RX_IDLE : RX_DATA;
                    next_st.bit_idx = '0;
                    next_st.char_bad = 1'b0;
                    next_st.par_acc = (st.cfg.frame == FRM_ODD_ONE);
                end
            end
            RX_DATA: begin
                if (bit_tick) begin
                    next_st.shift = {st.line, st.shift[7:1]}; // RULE_12
                    next_st.par_acc = st.par_acc ^ st.line;
                    next_st.bit_idx = st.bit_idx + 4'h1;
                    if (st.bit_idx == 4'h7) begin
                        next_st.bit_idx = '0;
                        next_st.rx = (st.cfg.frame <= FRM_ODD_ONE) ? RX_PAR : RX_STOP; // RULE_05
                    end
                end
            end
            RX_PAR: begin
                if (bit_tick) begin
                    next_st.char_bad = st.par_acc ^ st.line; // RULE_06
                    next_st.rx = RX_STOP;
                end
            end
            RX_STOP: begin
                if (bit_tick) begin
                    next_st.char_bad = next_st.char_bad | !st.line;
                    next_st.bit_idx = st.bit_idx + 4'h1;
                    if ((st.cfg.frame != FRM_NONE_TWO) || (st.bit_idx == 4'h1) || !st.line) begin
                        char_done = 1'b1;
                        next_st.rx = RX_IDLE;
                    end
                end
            end
            default: begin
                next_st.rx = RX_IDLE;
            end
        endcase

        // ****************************************
        // Message assembly, gap timer, CRC
        // ****************************************
        accept = char_done && modbus_sel(st.cfg.proto);
        ms_tick = (st.ms_div == 17'(CYC_PER_TICK - 1));
        next_st.ms_div = ms_tick ? '0 : st.ms_div + 17'h00001;
        if (accept) begin
            next_st.ms_div = '0; // RULE_15
            next_st.gap_cnt = '0;
            next_st.in_msg = 1'b1;
            if (!st.in_msg) begin
                next_st.crc = crc_byte(CRC_INIT, st.shift);
                next_st.nbytes = 4'h1;
                next_st.msg_addr = st.shift;
                next_st.msg_bad = next_st.char_bad;
            end else begin
                next_st.crc = crc_byte(st.crc, st.shift); // RULE_14
                next_st.nbytes = (st.nbytes == 4'hF) ? st.nbytes : st.nbytes + 4'h1;
                next_st.msg_bad = st.msg_bad | next_st.char_bad;
            end
            if (next_st.char_bad) begin
                next_st.status[ST_CHAR_ERR] = 1'b1;
            end
            if (fifo_ready) begin
                next_st.push = 1'b1;
                next_st.push_data = st.shift;
            end else begin
                next_st.msg_bad = 1'b1;
                next_st.status[ST_OVERRUN] = 1'b1;
            end
        end else if (st.in_msg && ms_tick && (st.rx == RX_IDLE)) begin
            next_st.gap_cnt = st.gap_cnt + 11'h001;
            if (st.gap_cnt >= st.cfg.gap_ms) begin
                next_st.in_msg = 1'b0; // RULE_07
                next_st.msg.done = 1'b1;
                next_st.msg.ok = (st.crc == 16'h0000) && !st.msg_bad && (st.nbytes >= MIN_MSG_BYTES); // RULE_08
                next_st.msg.broadcast = next_st.msg.ok && (st.msg_addr == BCAST_ADDR);
                next_st.msg.reply = next_st.msg.ok && (st.msg_addr != BCAST_ADDR)
                    && (st.msg_addr == st.cfg.slave_addr); // RULE_13
            end
        end
    end

    always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            st <= '0;
            st.cfg <= '{RST_BAUD, RST_PROTO, RST_FRAME, RST_GAP_MS, RST_ADDR};
            st.sync <= 3'h7;
            st.line <= 1'b1;
            st.rx <= RX_IDLE;
        end else begin
            st <= next_st;
        end
    end

    rx_byte_fifo #(
        .WIDTH(8),
        .DEPTH(4)
    ) u_fifo (
        .clk_sys_in(clk_sys_in),
        .rst_b_in(rst_b_in),
        .in_data_in(st.push_data),
        .in_valid_in(st.push),
        .in_ready_out(fifo_ready),
        .out_data_out(rx_data_out),
        .out_valid_out(rx_valid_out),
        .out_ready_in(rx_ready_in)
    );

    assign reg_rdata_out = st.rdata;
    assign msg_out = st.msg;
endmodule : modbus_rtu_serial_config
`default_nettype wire

// ===== hdl/modbus_cfg_pkg.sv
/*
 * Constants, offsets and carrier types of the Modbus RTU serial
 * configuration and receive-side message framer.
 * Assumes a single 100 MHz clock and a plain register port.
 */
// Overview of operation
// (RULE_01) Bit rate code 0..5, 300..9600, default 9600
// (RULE_02) Device bit rate must equal master's
// (RULE_03) Bit rate writes from link are refused
// (RULE_04) Protocol selector, default 0, Modbus code 3/1
// (RULE_05) Framing codes: even, odd, none/1, none/2
// (RULE_06) Device framing must equal master's framing
// (RULE_07) Gap over 10..2000 ms limit ends message
// (RULE_08) Failed CRC message discarded, no reply; its bytes still reach the FIFO, ok, reply and broadcast stay low
// (RULE_09) Master side: limit near 100 ms advised
// (RULE_10) Modbus address 1..247, default 1
// (RULE_11) Address writes from link are refused
// (RULE_12) Start, 8 data LSB first, parity, stops
// (RULE_13) Address zero is broadcast, never replied
// (RULE_14) CRC sent low byte first, high last
// (RULE_15) Gap timer restarts each stop, ms ticks
`default_nettype none
package modbus_cfg_pkg;
    localparam int CLK_HZ = 100_000_000;
    localparam int CLK_PERIOD_NS = 10;
    localparam int TICK_MS = 1;
    localparam int CYC_PER_MS = TICK_MS * 1_000_000 / CLK_PERIOD_NS;
    localparam int BAUD_MAX_BPS = 9600;
    localparam int CYC_PER_BIT_MAX = CLK_HZ / BAUD_MAX_BPS;
    localparam logic [2:0] BAUD_CODE_MAX = 3'h5;
    // Register offsets
    localparam logic [7:0] OFS_BAUD = 8'h00;
    localparam logic [7:0] OFS_PROTO = 8'h04;
    localparam logic [7:0] OFS_FRAME = 8'h08;
    localparam logic [7:0] OFS_GAP = 8'h0C;
    localparam logic [7:0] OFS_ADDR = 8'h10;
    localparam logic [7:0] OFS_STATUS = 8'h14;
    // Reset values and limits
    localparam logic [2:0] RST_BAUD = 3'h5;
    localparam logic [1:0] RST_PROTO = 2'h0;
    localparam logic [1:0] RST_FRAME = 2'h2;
    localparam logic [10:0] RST_GAP_MS = 11'h064;
    localparam logic [10:0] GAP_MIN_MS = 11'h00A;
    localparam logic [10:0] GAP_MAX_MS = 11'h7D0;
    localparam logic [7:0] RST_ADDR = 8'h01;
    localparam logic [7:0] MB_ADDR_MIN = 8'h01;
    localparam logic [7:0] MB_ADDR_MAX = 8'hF7;
    localparam logic [7:0] OTHER_ADDR_MAX = 8'h7E;
    localparam logic [7:0] BCAST_ADDR = 8'h00;
    // Framing codes
    localparam logic [1:0] FRM_EVEN_ONE = 2'h0;
    localparam logic [1:0] FRM_ODD_ONE = 2'h1;
    localparam logic [1:0] FRM_NONE_TWO = 2'h3;
    // Status bit positions
    localparam int ST_REJECT = 0;
    localparam int ST_CHAR_ERR = 1;
    localparam int ST_OVERRUN = 2;
    localparam int ST_IN_MSG = 3;
    localparam logic [15:0] CRC_INIT = 16'hFFFF;
    localparam logic [15:0] CRC_POLY = 16'hA001;
    localparam logic [3:0] MIN_MSG_BYTES = 4'h4;

    typedef struct packed {
        logic [2:0] baud;
        logic [1:0] proto;
        logic [1:0] frame;
        logic [10:0] gap_ms;
        logic [7:0] slave_addr;
    } cfg_s;

    typedef struct packed {
        logic done;
        logic ok;
        logic reply;
        logic broadcast;
    } msg_s;
endpackage : modbus_cfg_pkg
`default_nettype wire

// ===== verif/modbus_rtu_serial_config_asserts.sv
/*
 * Port-level checker for the Modbus RTU configuration and framer.
 * Assumes it is bound to the top module and sees only its ports.
 */
`default_nettype none
module modbus_rtu_serial_config_chk
    import modbus_cfg_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys_in,
    input wire logic rst_b_in,
    // Register port
    input wire logic [7:0] reg_addr_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    input wire logic reg_from_link_in,
    input wire logic [15:0] reg_rdata_out,
    // Line, bytes and report
    input wire logic rx_in,
    input wire logic [7:0] rx_data_out,
    input wire logic rx_valid_out,
    input wire logic rx_ready_in,
    input wire modbus_cfg_pkg::msg_s msg_out
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clk_sys_in); endclocking
    default disable iff (!rst_b_in);

    AST_BAUD_CODE_RANGE: assert property ($past(reg_rd_in) && $past(reg_addr_in) == OFS_BAUD
        |-> reg_rdata_out <= {13'h0000, BAUD_CODE_MAX}) else $error("baud code out of range");
    AST_BAUD_LINK_KEEP: assert property ((reg_rd_in && reg_addr_in == OFS_BAUD)
        ##1 (reg_wr_in && reg_from_link_in && reg_addr_in == OFS_BAUD) ##1 (reg_rd_in && reg_addr_in == OFS_BAUD)
        |=> reg_rdata_out == $past(reg_rdata_out, 2)) else $error("baud changed from link");
    AST_ADDR_LINK_KEEP: assert property ((reg_rd_in && reg_addr_in == OFS_ADDR)
        ##1 (reg_wr_in && reg_from_link_in && reg_addr_in == OFS_ADDR) ##1 (reg_rd_in && reg_addr_in == OFS_ADDR)
        |=> reg_rdata_out == $past(reg_rdata_out, 2)) else $error("address changed from link");
    AST_GAP_RANGE: assert property ($past(reg_rd_in) && $past(reg_addr_in) == OFS_GAP
        |-> reg_rdata_out >= {5'h00, GAP_MIN_MS} && reg_rdata_out <= {5'h00, GAP_MAX_MS}) else $error("gap out of range");
    AST_ADDR_RANGE: assert property ($past(reg_rd_in) && $past(reg_addr_in) == OFS_ADDR
        |-> reg_rdata_out <= {8'h00, MB_ADDR_MAX}) else $error("address out of range");
    AST_FRAME_FIELD: assert property ($past(reg_rd_in) && $past(reg_addr_in) == OFS_FRAME
        |-> reg_rdata_out[15:2] == 14'h0000) else $error("framing field too wide");
    AST_BCAST_SILENT: assert property (msg_out.done && msg_out.broadcast |-> !msg_out.reply)
        else $error("reply to broadcast");
    AST_BAD_CRC_DROP: assert property (msg_out.done && !msg_out.ok
        |-> !msg_out.reply && !msg_out.broadcast) else $error("failed message acted on");
    AST_DONE_PULSE: assert property (msg_out.done |=> !msg_out.done)
        else $error("message end longer than one cycle");
    AST_DONE_AFTER_IDLE: assert property (msg_out.done |-> $past(rx_in, 1) && $past(rx_in, 64))
        else $error("message end without idle line");
    AST_BYTE_HOLD: assert property (rx_valid_out && !rx_ready_in
        |=> rx_valid_out && $stable(rx_data_out)) else $error("byte lost while stalled");
endmodule : modbus_rtu_serial_config_chk

bind modbus_rtu_serial_config modbus_rtu_serial_config_chk modbus_rtu_serial_config_chk_inst (
    .clk_sys_in, .rst_b_in, .reg_addr_in, .reg_wr_in, .reg_rd_in, .reg_from_link_in, .reg_rdata_out,
    .rx_in, .rx_data_out, .rx_valid_out, .rx_ready_in, .msg_out);
`default_nettype wire

// ===== verif/mb_master.sv
/*
 * Behavioural bus master that sends framed Modbus RTU queries.
 * Assumes tasks are called just after a rising clock edge.
 */
`default_nettype none
module mb_master (
    // Clock
    input wire logic clk_sys_in,
    // Serial line, idle high
    output logic rx_out
);
    timeunit 1ns;
    timeprecision 1ps;
    initial rx_out = 1'b1;

    function automatic logic [15:0] crc16(input logic [15:0] c, input logic [7:0] b);
        c = c ^ {8'h00, b};
        for (int i = 0; i < 8; i++) c = c[0] ? (c >> 1) ^ 16'hA001 : c >> 1;
        return c;
    endfunction : crc16

    task automatic put_bit(input logic v, input int cpb);
        rx_out <= v;
        repeat (cpb) @(posedge clk_sys_in);
    endtask : put_bit

    // Same rate and framing as the device is set to
    task automatic send_byte(input logic [7:0] b, input logic [1:0] frm, input int cpb);
        put_bit(1'b0, cpb);
        for (int i = 0; i < 8; i++) put_bit(b[i], cpb);
        if (frm < 2'h2) put_bit(frm[0] ? ~^b : ^b, cpb);
        put_bit(1'b1, cpb);
        if (frm == 2'h3) put_bit(1'b1, cpb);
    endtask : send_byte

    // Back-to-back characters, well inside any gap limit
    task automatic send_msg(input logic [7:0] a, input int n, input logic [1:0] frm, input int cpb,
        input bit bad);
        logic [15:0] crc;
        logic [7:0] b;
        crc = 16'hFFFF;
        for (int k = 0; k < n; k++) begin
            b = (k == 0) ? a : 8'h10 + 8'(k);
            crc = crc16(crc, b);
            send_byte(b, frm, cpb);
        end
        crc[0] = crc[0] ^ bad;
        send_byte(crc[7:0], frm, cpb);
        send_byte(crc[15:8], frm, cpb);
    endtask : send_msg
endmodule : mb_master
`default_nettype wire

// ===== verif/modbus_rtu_serial_config_tb.sv
/*
 * Self-checking bench for the Modbus RTU configuration and framer.
 * Assumes shortened bit and millisecond counts set below.
 */
`default_nettype none
module modbus_rtu_serial_config_tb;
    import modbus_cfg_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct {bit link; logic [7:0] ofs; logic [15:0] wd; logic [15:0] exp;} reg_row_s;
    typedef struct {logic [1:0] frm; logic [2:0] baud; logic [7:0] adr; bit bad; logic [2:0] exp;} ser_row_s;
    logic clk_sys_in, rst_b_in, reg_wr_in, reg_rd_in, reg_from_link_in, rx_in, rx_valid_out, rx_ready_in;
    logic [7:0] reg_addr_in, rx_data_out;
    logic [15:0] reg_wdata_in, reg_rdata_out;
    msg_s msg_out;
    int n_fail = 0;
    int checks_done = 0;
    int cyc;
    logic [7:0] got[$];
    reg_row_s rr[23] = '{'{0, OFS_BAUD, 16'h0006, 16'h0005}, '{1, OFS_BAUD, 16'h0003, 16'h0005},
        '{0, OFS_BAUD, 16'h0000, 16'h0000}, '{0, OFS_BAUD, 16'h0005, 16'h0005},
        '{0, OFS_ADDR, 16'h007F, 16'h0001}, '{0, OFS_ADDR, 16'h0000, 16'h0000},
        '{0, OFS_PROTO, 16'h0004, 16'h0000}, '{0, OFS_PROTO, 16'h0003, 16'h0003},
        '{0, OFS_GAP, 16'h0009, 16'h0064}, '{0, OFS_GAP, 16'h07D1, 16'h0064},
        '{0, OFS_GAP, 16'h07D0, 16'h07D0}, '{0, OFS_GAP, 16'h000A, 16'h000A},
        '{0, OFS_ADDR, 16'h0000, 16'h0000}, '{0, OFS_ADDR, 16'h00F8, 16'h0000},
        '{0, OFS_ADDR, 16'h00F7, 16'h00F7}, '{1, OFS_ADDR, 16'h0005, 16'h00F7},
        '{0, OFS_ADDR, 16'h0022, 16'h0022}, '{0, OFS_FRAME, 16'h0000, 16'h0000},
        '{0, OFS_FRAME, 16'h0001, 16'h0001}, '{0, OFS_FRAME, 16'h0003, 16'h0003},
        '{0, OFS_FRAME, 16'h0002, 16'h0002}, '{0, 8'h18, 16'h1234, 16'h0000},
        '{0, OFS_STATUS, 16'h0000, 16'h0001}};
    ser_row_s sr[13] = '{'{2, 5, 8'h22, 0, 3'b110}, '{0, 5, 8'h22, 0, 3'b110}, '{1, 5, 8'h22, 0, 3'b110},
        '{3, 5, 8'h22, 0, 3'b110}, '{2, 4, 8'h22, 0, 3'b110}, '{2, 3, 8'h22, 0, 3'b110},
        '{2, 2, 8'h22, 0, 3'b110}, '{2, 1, 8'h22, 0, 3'b110}, '{2, 0, 8'h22, 0, 3'b110},
        '{2, 5, 8'h00, 0, 3'b101}, '{2, 5, 8'h23, 0, 3'b100}, '{2, 5, 8'h22, 1, 3'b000},
        '{2, 5, 8'h22, 0, 3'b110}};

    modbus_rtu_serial_config #(.CYC_PER_BIT_FAST(16), .CYC_PER_TICK(50)) modbus_rtu_serial_config_inst (
        .clk_sys_in(clk_sys_in), .rst_b_in(rst_b_in), .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
        .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_from_link_in(reg_from_link_in),
        .reg_rdata_out(reg_rdata_out), .rx_in(rx_in), .rx_data_out(rx_data_out), .rx_valid_out(rx_valid_out),
        .rx_ready_in(rx_ready_in), .msg_out(msg_out));
    mb_master mb_master_inst (.clk_sys_in(clk_sys_in), .rx_out(rx_in));

    // ****************************************
    // Clock, byte sink, watchdog
    // ****************************************
    initial begin
        clk_sys_in = 1'b0;
        forever #5 clk_sys_in = ~clk_sys_in;
    end
    always @(posedge clk_sys_in) if (rx_valid_out && rx_ready_in) got.push_back(rx_data_out);
    initial begin
        repeat (90000) @(posedge clk_sys_in);
        n_fail++;
        print_verdict();
    end

    // ****************************************
    // Tasks
    // ****************************************
    task automatic chk(input logic [15:0] act, input logic [15:0] exp);
        checks_done++;
        if (act !== exp) begin
            n_fail++;
            $display("mismatch t=%0t act=%h exp=%h", $time, act, exp);
        end
    endtask : chk
    task automatic reg_wr(input bit link, input logic [7:0] a, input logic [15:0] d);
        @(posedge clk_sys_in);
        {reg_wr_in, reg_from_link_in, reg_addr_in, reg_wdata_in} <= {1'b1, link, a, d};
        @(posedge clk_sys_in);
        {reg_wr_in, reg_from_link_in} <= 2'b00;
    endtask : reg_wr
    task automatic reg_rd(input logic [7:0] a, input logic [15:0] exp);
        @(posedge clk_sys_in);
        {reg_rd_in, reg_addr_in} <= {1'b1, a};
        @(posedge clk_sys_in);
        reg_rd_in <= 1'b0;
        #1 chk(reg_rdata_out, exp);
    endtask : reg_rd
    task automatic b2b(input logic [7:0] a, input logic [15:0] exp);
        @(posedge clk_sys_in);
        {reg_rd_in, reg_addr_in} <= {1'b1, a};
        @(posedge clk_sys_in);
        {reg_rd_in, reg_wr_in, reg_from_link_in, reg_wdata_in} <= {3'b011, 16'h0003};
        @(posedge clk_sys_in);
        {reg_rd_in, reg_wr_in, reg_from_link_in} <= 3'b100;
        @(posedge clk_sys_in);
        reg_rd_in <= 1'b0;
        #1 chk(reg_rdata_out, exp);
    endtask : b2b
    task automatic wait_done();
        cyc = 0;
        while (msg_out.done !== 1'b1 && cyc < 1000) begin
            @(posedge clk_sys_in);
            #1 cyc++;
        end
    endtask : wait_done
    task automatic print_verdict();
        if (n_fail == 0 && checks_done > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : print_verdict

    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        {reg_wr_in, reg_rd_in, reg_from_link_in, reg_addr_in, reg_wdata_in} = '0;
        rx_ready_in = 1'b1;
        rst_b_in = 1'b0;
        repeat (20) @(posedge clk_sys_in);
        rst_b_in <= 1'b1;
        foreach (rr[i]) begin
            reg_wr(rr[i].link, rr[i].ofs, rr[i].wd);
            reg_rd(rr[i].ofs, rr[i].exp);
        end
        reg_wr(0, OFS_STATUS, 16'h0001);
        reg_rd(OFS_STATUS, 16'h0000);
        foreach (sr[i]) begin
            reg_wr(0, OFS_FRAME, {14'h0000, sr[i].frm});
            reg_wr(0, OFS_BAUD, {13'h0000, sr[i].baud});
            got.delete();
            mb_master_inst.send_msg(sr[i].adr, 3, sr[i].frm, 16 << (5 - sr[i].baud), sr[i].bad);
            wait_done();
            chk({15'h0000, cyc + (8 << (5 - sr[i].baud)) inside {[540:575]}}, 16'h0001);
            chk({13'h0000, msg_out[2:0]}, {13'h0000, sr[i].exp});
            chk(16'(got.size()), 16'h0005);
            for (int k = 0; k < 3; k++) chk(got[k], (k == 0) ? sr[i].adr : 8'h10 + 8'(k));
        end
        b2b(OFS_BAUD, 16'h0005);
        b2b(OFS_ADDR, 16'h0022);
        reg_wr(0, OFS_PROTO, 16'h0000);
        got.delete();
        mb_master_inst.send_msg(8'h22, 1, 2'h2, 16, 0);
        repeat (700) @(posedge clk_sys_in);
        chk(16'(got.size()), 16'h0000);
        reg_wr(0, OFS_PROTO, 16'h0003);
        rx_ready_in <= 1'b0;
        got.delete();
        mb_master_inst.send_msg(8'h22, 5, 2'h2, 16, 0);
        wait_done();
        chk({15'h0000, msg_out.done}, 16'h0001);
        chk({13'h0000, msg_out[2:0]}, 16'h0000);
        rx_ready_in <= 1'b1;
        repeat (20) @(posedge clk_sys_in);
        chk(16'(got.size()), 16'h0005);
        reg_rd(OFS_STATUS, 16'h0005);
        rst_b_in <= 1'b0;
        repeat (3) @(posedge clk_sys_in);
        chk({12'h000, msg_out}, 16'h0000);
        rst_b_in <= 1'b1;
        reg_rd(OFS_BAUD, {13'h0000, RST_BAUD});
        reg_rd(OFS_PROTO, {14'h0000, RST_PROTO});
        reg_rd(OFS_FRAME, {14'h0000, RST_FRAME});
        reg_rd(OFS_GAP, {5'h00, RST_GAP_MS});
        reg_rd(OFS_ADDR, {8'h00, RST_ADDR});
        print_verdict();
    end
endmodule : modbus_rtu_serial_config_tb
`default_nettype wire
